// ==== rtl/adc_control_defines.svh ====
// Register offsets, field positions, reset values and divider counts of the converter control unit.
`ifndef ADC_CONTROL_DEFINES_SVH
`define ADC_CONTROL_DEFINES_SVH
`define OFS_PRIMARY       8'h00
`define OFS_SECONDARY     8'h04
`define OFS_RESULT_HIGH   8'h08
`define OFS_RESULT_LOW    8'h0C
`define OFS_IRQ_STATUS    8'h10
`define OFS_IRQ_CLEAR     8'h14
`define OFS_IRQ_ENABLE    8'h18
`define BIT_GO            2
`define BIT_POWER         0
`define BIT_DONE_FLAG     0
`define PRIMARY_RESET     8'h00
`define SECONDARY_RESET   8'h00
`define RESULT_RESET      10'h000
`define SAR_FIRST_TRIAL   10'h200
`define SAR_MSB_INDEX     4'h9
`define DIV_LAST_2        6'h01
`define DIV_LAST_4        6'h03
`define DIV_LAST_8        6'h07
`define DIV_LAST_16       6'h0F
`define DIV_LAST_32       6'h1F
`define DIV_LAST_64       6'h3F
`define CLK_SEL_RC        2'h3
`endif

// ==== rtl/adc_control_pkg.sv ====
// Types shared by the converter control unit.
package adc_control_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONVERT = 2'b10} seq_state_t;
  typedef struct packed {
    logic [1:0] conv_clock_select_low;
    logic [2:0] input_channel_select;
    logic       go;
    logic       unused;
    logic       converter_power_on;
  } primary_t;
  typedef struct packed {
    logic       result_justify_select;
    logic       conv_clock_select_upper;
    logic [1:0] unused;
    logic [3:0] port_config;
  } secondary_t;
  typedef struct packed {
    logic       power;
    logic [2:0] channel;
    logic       hold;
    logic [9:0] dac_code;
    logic [7:0] analog_mask;
  } core_ctrl_t;
endpackage

// ==== rtl/adc_control_unit.sv ====
// APB controlled sequencer for a 10-bit successive approximation converter.
// Summary of operation
// R01: Each started conversion yields a 10-bit result; an aborted one leaves the old result.
// R02: Result high, result low, primary, secondary registers.
// R03: Primary runs conversions; secondary sets analog pins.
// R04: Primary fields: clock 7-6, channel 5-3, go, power.
// R05: Upper bit 0: divide by 2, 8, 32.
// R06: Upper bit 1: divide 4, 16, 64; 11 RC.
// R07: Channel field value n routes input n.
// R08: Software avoids channel codes absent on small package.
// R09: Writing go while powered starts; reads 1 busy.
// R10: Hardware clears go when conversion completes.
// R11: Power bit powers converter; clear shuts it off.
// R12: Primary bit 1 reads zero, ignores writes.
// R13: Implemented primary bits read/write, reset to zero.
// R14: Secondary bit 6 picks divider encoding half.
// R15: Completion loads result, clears go, sets flag.
// R16: Justify bit zeroes six high or low bits.
// R17: Reset powers off and aborts running conversion.
// R18: Go written with power off starts nothing.
// R19: One result bit per conversion clock, MSB first.
`timescale 1ns/1ps
`include "adc_control_defines.svh"
module adc_control_unit
(
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        comp_above,
  input  wire logic                        rc_clk_in,
  output adc_control_pkg::core_ctrl_t      core_ctrl,
  output logic                             irq
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  adc_control_pkg::primary_t   prim_reg;
  adc_control_pkg::secondary_t sec_reg;
  adc_control_pkg::seq_state_t state_reg;
  adc_control_pkg::core_ctrl_t core_reg;
  logic [9:0]  result_reg;
  logic [9:0]  code_reg;
  logic [3:0]  bit_reg;
  logic [5:0]  div_cnt_reg;
  logic [5:0]  div_last;
  logic        status_reg;
  logic        enable_reg;
  logic        irq_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        comp_s1_reg;
  logic        comp_s2_reg;
  logic        rc_s1_reg;
  logic        rc_s2_reg;
  logic        rc_s3_reg;
  logic        rc_armed_reg;
  logic        wr_acc;
  logic        setup;
  logic        addr_hit;
  logic        start;
  logic        abort;
  logic        tick;
  logic        done;
  logic        clr_done;
  logic [7:0]  rd_byte;

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign core_ctrl = core_reg;
  assign irq       = irq_reg;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready_reg && pwrite;
  assign addr_hit = (paddr == `OFS_PRIMARY) || (paddr == `OFS_SECONDARY) || (paddr == `OFS_RESULT_HIGH)
                 || (paddr == `OFS_RESULT_LOW) || (paddr == `OFS_IRQ_STATUS) || (paddr == `OFS_IRQ_CLEAR)
                 || (paddr == `OFS_IRQ_ENABLE);

  always_comb
  begin
    rd_byte = 8'h00;
    case (paddr)
      `OFS_PRIMARY:     rd_byte = {prim_reg[7:2], 1'b0, prim_reg.converter_power_on}; // see R12
      `OFS_SECONDARY:   rd_byte = {sec_reg[7:6], 2'b00, sec_reg.port_config};
      `OFS_RESULT_HIGH: rd_byte = sec_reg.result_justify_select ? {6'h00, result_reg[9:8]} : result_reg[9:2]; // see R16
      `OFS_RESULT_LOW:  rd_byte = sec_reg.result_justify_select ? result_reg[7:0] : {result_reg[1:0], 6'h00}; // see R16
      `OFS_IRQ_STATUS:  rd_byte = {7'h00, status_reg};
      `OFS_IRQ_ENABLE:  rd_byte = {7'h00, enable_reg};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Every transfer gets exactly one wait-free access phase, so pready can come from a flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !addr_hit;
      prdata_reg  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000; // see R02
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  assign start = wr_acc && (paddr == `OFS_PRIMARY) && pwdata[`BIT_GO] && pwdata[`BIT_POWER]
              && (state_reg == adc_control_pkg::ST_IDLE); // see R09 see R18
  assign abort = wr_acc && (paddr == `OFS_PRIMARY) && !pwdata[`BIT_POWER]; // see R11

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      prim_reg <= `PRIMARY_RESET; // see R13 see R17
      sec_reg  <= `SECONDARY_RESET;
    end
    else
    begin
      if (wr_acc && (paddr == `OFS_PRIMARY))
      begin
        prim_reg.conv_clock_select_low <= pwdata[7:6]; // see R04
        prim_reg.input_channel_select  <= pwdata[5:3];
        prim_reg.converter_power_on    <= pwdata[`BIT_POWER]; // see R11
      end
      if (start)
        prim_reg.go <= 1'b1; // see R09
      else if (done || abort)
        prim_reg.go <= 1'b0; // see R10
      if (wr_acc && (paddr == `OFS_SECONDARY))
        sec_reg <= {pwdata[7:6], 2'b00, pwdata[3:0]}; // see R03 see R14
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
      rc_s1_reg   <= 1'b0;
      rc_s2_reg   <= 1'b0;
      rc_s3_reg   <= 1'b0;
    end
    else
    begin
      comp_s1_reg <= comp_above;
      comp_s2_reg <= comp_s1_reg;
      rc_s1_reg   <= rc_clk_in;
      rc_s2_reg   <= rc_s1_reg;
      rc_s3_reg   <= rc_s2_reg;
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  // The comparator passes a two-flop synchroniser, so divide by two leaves it two periods
  // stale and divide by four one; those settings suit only a comparator path with less latency.
  always_comb
  begin
    case ({sec_reg.conv_clock_select_upper, prim_reg.conv_clock_select_low}) // see R14
      3'b000:  div_last = `DIV_LAST_2; // see R05
      3'b001:  div_last = `DIV_LAST_8;
      3'b010:  div_last = `DIV_LAST_32;
      3'b100:  div_last = `DIV_LAST_4; // see R06
      3'b101:  div_last = `DIV_LAST_16;
      3'b110:  div_last = `DIV_LAST_64;
      default: div_last = `DIV_LAST_2;
    endcase
  end

  // The first RC edge after start only opens a full period, so the first trial sees a settled comparator.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || (state_reg != adc_control_pkg::ST_CONVERT))
      rc_armed_reg <= 1'b0;
    else if (rc_s2_reg && !rc_s3_reg)
      rc_armed_reg <= 1'b1;
  end

  assign tick = (state_reg == adc_control_pkg::ST_CONVERT)
             && ((prim_reg.conv_clock_select_low == `CLK_SEL_RC)
                 ? (rc_armed_reg && rc_s2_reg && !rc_s3_reg) // see R06 see R19
                 : (div_cnt_reg == div_last));

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      div_cnt_reg <= 6'h00;
    else if (tick || (state_reg != adc_control_pkg::ST_CONVERT))
      div_cnt_reg <= 6'h00;
    else
      div_cnt_reg <= div_cnt_reg + 6'h01;
  end

  // ****************************************************************
  // Successive approximation sequencer
  // ****************************************************************
  assign done = tick && (bit_reg == 4'h0) && !abort;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      state_reg <= adc_control_pkg::ST_IDLE; // see R17
    else
    begin
      case (state_reg)
        adc_control_pkg::ST_IDLE:
          if (start)
            state_reg <= adc_control_pkg::ST_CONVERT;
        adc_control_pkg::ST_CONVERT:
          if (done || abort)
            state_reg <= adc_control_pkg::ST_IDLE; // see R17
        default:
          state_reg <= adc_control_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      code_reg <= `RESULT_RESET;
      bit_reg  <= 4'h0;
    end
    else if (start)
    begin
      code_reg <= `SAR_FIRST_TRIAL; // see R19
      bit_reg  <= `SAR_MSB_INDEX;
    end
    else if (tick)
    begin
      code_reg[bit_reg] <= comp_s2_reg; // see R19
      if (bit_reg != 4'h0)
      begin
        code_reg[bit_reg - 4'h1] <= 1'b1;
        bit_reg <= bit_reg - 4'h1;
      end
    end
  end

  // Result holds its last value across an aborted conversion.
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      result_reg <= `RESULT_RESET;
    else if (done)
      result_reg <= {code_reg[9:1], comp_s2_reg}; // see R01 see R15
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  assign clr_done = wr_acc && (paddr == `OFS_IRQ_CLEAR) && pwdata[`BIT_DONE_FLAG];

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      status_reg <= 1'b0;
      enable_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      status_reg <= done || (status_reg && !clr_done); // see R15
      if (wr_acc && (paddr == `OFS_IRQ_ENABLE))
        enable_reg <= pwdata[`BIT_DONE_FLAG];
      irq_reg <= status_reg && enable_reg;
    end
  end

  // ****************************************************************
  // Converter core drive
  // ****************************************************************
  function automatic logic [7:0] analog_mask_of(input logic [3:0] cfg);
    case (cfg)
      4'h0:    analog_mask_of = 8'hFF;
      4'h1:    analog_mask_of = 8'hF7;
      4'h2:    analog_mask_of = 8'h1F;
      4'h3:    analog_mask_of = 8'h17;
      4'h4:    analog_mask_of = 8'h0B;
      4'h5:    analog_mask_of = 8'h03;
      4'h8:    analog_mask_of = 8'hF3;
      4'h9:    analog_mask_of = 8'h3F;
      4'hA:    analog_mask_of = 8'h37;
      4'hB:    analog_mask_of = 8'h33;
      4'hC:    analog_mask_of = 8'h13;
      4'hD:    analog_mask_of = 8'h03;
      4'hE:    analog_mask_of = 8'h01;
      4'hF:    analog_mask_of = 8'h01;
      default: analog_mask_of = 8'h00;
    endcase
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      core_reg <= '0;
    else
    begin
      core_reg.power       <= prim_reg.converter_power_on; // see R11
      core_reg.channel     <= prim_reg.input_channel_select; // see R07
      core_reg.hold        <= (state_reg == adc_control_pkg::ST_CONVERT);
      core_reg.dac_code    <= code_reg;
      core_reg.analog_mask <= analog_mask_of(sec_reg.port_config); // see R03
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_start_sets_busy: assert property (start |=> prim_reg.go && (state_reg == adc_control_pkg::ST_CONVERT)) // see R09
    else $error("go not set after start");
  a_no_start_off: assert property ((wr_acc && paddr == `OFS_PRIMARY && !pwdata[`BIT_POWER]) |=> !prim_reg.go) // see R18
    else $error("conversion running while powered off");
  a_power_gates_go: assert property (!prim_reg.converter_power_on |-> !prim_reg.go) // see R11
    else $error("go set with power off");
  a_done_flags: assert property (done |=> !prim_reg.go && status_reg && result_reg == $past({code_reg[9:1], comp_s2_reg})) // see R15
    else $error("completion effects missing");
  a_bit1_zero: assert property ((pready_reg && !pwrite && $past(paddr) == `OFS_PRIMARY) |-> prdata_reg[1] == 1'b0) // see R12
    else $error("primary bit 1 reads one");
  a_justify_high: assert property ((setup && !pwrite && paddr == `OFS_RESULT_HIGH && sec_reg.result_justify_select)
                                   |=> prdata_reg[7:2] == 6'h00) // see R16
    else $error("right justified high byte not zero on top");
  a_irq_level: assert property (irq_reg == $past(status_reg && enable_reg)) // see R15
    else $error("interrupt level mismatch");
  a_div_fast: assert property ((tick && bit_reg > 4'h1 && div_last == `DIV_LAST_2
                                && prim_reg.conv_clock_select_low != `CLK_SEL_RC && !abort) |=> !tick ##1 tick) // see R05
    else $error("divide by two tick spacing wrong");

  c_conversion_done: cover property (start ##[1:1000] done);
  c_abort_running: cover property ((state_reg == adc_control_pkg::ST_CONVERT) && abort);
  c_irq_raised: cover property (done ##1 status_reg ##1 irq_reg);
endmodule

// ==== tb/adc_core_model.sv ====
// Behavioural model of the analog multiplexer, comparator and internal RC oscillator.
`timescale 1ns/1ps
module adc_core_model
(
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire adc_control_pkg::core_ctrl_t core_ctrl,
  input  wire logic [79:0]                 levels,
  output logic                             comp_above,
  output logic                             rc_clk_in
);
  logic [9:0] level;

  // The eight-input variant is modelled, so every channel code is legal here.
  assign level = levels[core_ctrl.channel * 10 +: 10];

  // The comparator output is not pulled, so outside a conversion it toggles.
  // This keeps a sequencer from passing on a stale level it should not sample.
  always @(posedge ref_clk)
  begin
    if (!rstn)
      comp_above <= 1'b0;
    else if (core_ctrl.power && core_ctrl.hold)
      comp_above <= level >= core_ctrl.dac_code;
    else
      comp_above <= ~comp_above;
  end

  // The RC oscillator runs free and slower than the fastest divided clock.
  initial
  begin
    rc_clk_in = 1'b0;
    forever #130 rc_clk_in = ~rc_clk_in;
  end
endmodule

// ==== tb/tb_adc_control_unit.sv ====
// Self-checking bench for the converter control unit.
`timescale 1ns/1ps
`include "adc_control_defines.svh"
module tb_adc_control_unit;
  localparam int LIMIT = 60000;
  logic                        ref_clk;
  logic                        rstn;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [7:0]                  paddr;
  logic [31:0]                 pwdata;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        comp_above;
  logic                        rc_clk_in;
  adc_control_pkg::core_ctrl_t core_ctrl;
  logic                        irq;
  logic [79:0]                 levels;
  logic [31:0]                 seed;
  logic [31:0]                 rq;
  logic                        re;
  logic                        hold_q = 1'b0;
  int                          n_fail = 0;
  int                          check_count = 0;
  int                          cyc = 0;
  int                          t_rise = 0;
  int                          hold_len = 0;

  adc_control_unit dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .rc_clk_in(rc_clk_in), .core_ctrl(core_ctrl), .irq(irq));

  adc_core_model core_u (.ref_clk(ref_clk), .rstn(rstn), .core_ctrl(core_ctrl), .levels(levels),
    .comp_above(comp_above), .rc_clk_in(rc_clk_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [15:0] just(input logic [9:0] r, input logic rj);
    return rj ? {6'h00, r} : {r, 6'h00};
  endfunction

  task automatic results();
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1);
    chk("pready wait", n, 1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic poll();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `OFS_PRIMARY, 32'h0);
      k++;
    end
    while (rq[2] === 1'b1 && k < 300);
    chk("go cleared", rq[2], 1'b0);
  endtask

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (core_ctrl.hold === 1'b1 && !hold_q)
      t_rise <= cyc;
    if (core_ctrl.hold === 1'b0 && hold_q)
      hold_len <= cyc - t_rise;
    hold_q <= core_ctrl.hold === 1'b1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    logic [7:0] ofs [6];
    logic [7:0] d;
    logic [9:0] lvl;
    logic [2:0] ch;
    logic [15:0] res;
    int dv;
    ofs = '{`OFS_PRIMARY, `OFS_SECONDARY, `OFS_RESULT_HIGH, `OFS_RESULT_LOW, `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE};
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    levels = 80'h0;
    seed = 32'h0000004B;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk("reset value", rq, 32'h0);
    end
    chk("analog mask", core_ctrl.analog_mask, 8'hFF);
    apb(1'b1, `OFS_RESULT_HIGH, 32'hFF);
    apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
    chk("result read only", rq, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {re, rq}, 33'h100000000);
    apb(1'b1, `OFS_PRIMARY, 32'hFB);
    apb(1'b0, `OFS_PRIMARY, 32'h0);
    chk("primary rw", rq, 32'hF9);
    chk("power pin", core_ctrl.power, 1'b1);
    apb(1'b1, `OFS_PRIMARY, 32'h04);
    apb(1'b0, `OFS_PRIMARY, 32'h0);
    chk("go unpowered", {rq, core_ctrl.hold}, 33'h0);
    for (int m = 0; m < 8; m++)
    begin
      seed = xs(seed);
      lvl = seed[9:0];
      ch = seed[12:10];
      levels[ch * 10 +: 10] <= lvl;
      d = {seed[13], m[2], 2'b11, seed[17:14]};
      apb(1'b1, `OFS_SECONDARY, d);
      apb(1'b0, `OFS_SECONDARY, 32'h0);
      chk("secondary", rq, {24'h0, d & 8'hCF});
      apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
      apb(1'b1, `OFS_PRIMARY, {24'h0, m[1:0], ch, 3'b101});
      apb(1'b0, `OFS_PRIMARY, 32'h0);
      chk("busy", rq[2], 1'b1);
      chk("channel", core_ctrl.channel, ch);
      poll();
      apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
      res[15:8] = rq[7:0];
      apb(1'b0, `OFS_RESULT_LOW, 32'h0);
      res[7:0] = rq[7:0];
      dv = (2 << (2 * m[1:0])) << m[2];
      if (m[1:0] != 2'b11)
        chk("ticks", hold_len >= 10 * dv - 2 && hold_len <= 10 * dv + 2, 1'b1);
      if (m[1:0] != 2'b00)
        chk("result", res, just(lvl, d[7]));
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk("flag and irq", {rq, irq}, 33'h3);
      apb(1'b1, `OFS_IRQ_CLEAR, 32'h1);
      apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
      chk("flag cleared", {rq, irq}, 33'h0);
    end
    // A slow conversion cut short by power-off leaves no flag behind.
    apb(1'b1, `OFS_SECONDARY, 32'h40);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
    apb(1'b1, `OFS_PRIMARY, 32'h85);
    apb(1'b1, `OFS_PRIMARY, 32'h80);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("abort flag", {rq, core_ctrl.hold}, 33'h0);
    apb(1'b0, `OFS_PRIMARY, 32'h0);
    chk("abort go", rq, 32'h80);
    apb(1'b1, `OFS_PRIMARY, 32'h05);
    poll();
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("masked irq", {rq, irq}, 33'h2);
    apb(1'b1, `OFS_PRIMARY, 32'h85);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `OFS_PRIMARY, 32'h0);
    chk("reset abort", {rq, core_ctrl.hold}, 33'h0);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("reset flag", rq, 32'h0);
    results();
  end
endmodule
